// file: design/hbs_defines.vh
`ifndef HBS_DEFINES_VH
`define HBS_DEFINES_VH

// =============================================================
// Word layout
`define HBS_WORD_W         16
`define HBS_CMD_OVERVOLTAGE_LOCKOUT_CTRL_BIT   15
`define HBS_CMD_OCD_BIT    13
`define HBS_CMD_SRR_BIT    0
`define HBS_DRV_LSB        1
`define HBS_DRV_MSB        6
`define HBS_ST_PSF_BIT     15
`define HBS_ST_ULD_BIT     14
`define HBS_ST_OLD_BIT     13
`define HBS_ST_TW_BIT      0

// =============================================================
// Reset values
`define HBS_CMD_RESET      16'h0000
`define HBS_FLAG_RESET     4'h0
`define HBS_SYNC_RESET     14'h2000
`define HBS_EDGE_RESET     3'h4

// =============================================================
// Timing: fault filter time in ns, clock rate in MHz
`define HBS_FILTER_NS      25000
`define HBS_CLK_MHZ        40
`define HBS_FILTER_CYC     ((`HBS_FILTER_NS * `HBS_CLK_MHZ + 999) / 1000)

`endif

// file: design/hbs_fifo.v
`timescale 1ns/10ps

// =============================================================
// Small FIFO: valid/ready on both sides, honest full and empty
module hbs_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Fill side
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    // Drain side
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];  // Storage words
    reg [AW-1:0]    wr_q;               // Write pointer
    reg [AW-1:0]    rd_q;               // Read pointer
    reg [AW:0]      cnt_q;              // Fill level
    wire            push;
    wire            pop;
    integer         k;

    assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    // Head word comes straight from a storage register
    assign o_out_data  = mem_q[rd_q];

    // =============================================================
    // Pointers and level
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            for (k = 0; k < DEPTH; k = k + 1)
                mem_q[k] <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_q] <= i_in_data;
                wr_q        <= wr_q + 1'b1;
            end
            if (pop)
                rd_q <= rd_q + 1'b1;
            // Level moves only when exactly one side acts
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// file: design/hbs_spi.v
`timescale 1ns/10ps
`include "hbs_defines.vh"

// How it works
// - Commands and status are 16-bit words
// - Both directions shift least significant bit first
// - Serial out released whenever select is high
// - Latch only when edge count is 16 multiple
// - Counter armed at select fall, counts rises
// - Valid frame clears the fault register
// - Persisting faults re-latch after filter time
// - Status shifts out while command shifts in
// - Daisy chain through serial out to in
// - Command bit 15 enables overvoltage shutdown
// - Command bit 13 enables overcurrent shutdown
// - Command bit 0 clears latched status
// - Bits 6..1 are drivers, status 0 thermal
// - Status bit 15 reports supply fault
// - Status bit 14 reports under-load
// - Status bit 13 reports overload
// - Wake low sleeps; floating select blocks
// - Overcurrent flags, or latches driver off
// - Overvoltage forces off, keeps programmed states
// - Select fall shows thermal warning first
// - Supply fault held until clear command
module hbs_spi #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW    = 2,
    parameter FILTER_CYC = `HBS_FILTER_CYC
) (
    // Clock and reset
    input  wire       I_SYS_CLK,
    input  wire       I_RST_N,
    // Serial link pins
    input  wire       I_SELECT_N,
    input  wire       I_SHIFT_CLOCK,
    input  wire       I_SERIAL_IN,
    output wire       O_SERIAL_OUT,
    output wire       O_SERIAL_OUT_OE_N,
    // Sleep control pin
    input  wire       I_WAKE,
    // Fault detector levels from the analog side
    input  wire [5:0] I_OVERCURRENT,
    input  wire       I_UNDERLOAD,
    input  wire       I_OVERVOLTAGE,
    input  wire       I_UNDERVOLTAGE,
    input  wire       I_THERMAL_WARN,
    // Driver gates and state
    output wire [5:0] O_DRIVER_ON,
    output wire       O_SLEEP
);
    // =============================================================
    // Input synchronisers: stage one feeds only stage two
    // Pin order: select, clock, data, wake, then fault levels
    localparam NS = 14;
    wire [NS-1:0] raw_in;
    reg  [NS-1:0] sync1_q;   // First stage, read by stage two only
    reg  [NS-1:0] sync2_q;   // Safe levels
    reg  [2:0]    pin3_q;    // Delayed copies for edge finding

    // One bus keeps both stages in lockstep for every pin
    assign raw_in = {I_SELECT_N, I_SHIFT_CLOCK, I_SERIAL_IN, I_WAKE,
                     I_THERMAL_WARN, I_UNDERVOLTAGE, I_OVERVOLTAGE,
                     I_UNDERLOAD, I_OVERCURRENT};

    // Select resets high so a dead link reads as idle
    always @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            sync1_q <= `HBS_SYNC_RESET;
            sync2_q <= `HBS_SYNC_RESET;
            pin3_q  <= `HBS_EDGE_RESET;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
            pin3_q  <= sync2_q[13:11];
        end
    end

    // =============================================================
    // Qualified link levels and edge strobes
    // Each edge compares stage two with its delayed copy, so a pin
    // edge yields one single-cycle strobe, or none while select is high or in sleep
    wire       wake     = sync2_q[10];
    wire       sleep    = ~wake;
    // Sleep blocks transfers, as a floating select would
    wire       sel_n    = sync2_q[13] | sleep;
    wire       sel_n_d  = pin3_q[2] | sleep;
    wire       sclk     = sync2_q[12];
    wire       sin      = sync2_q[11];
    // Select edges use the sleep-masked level, so entering sleep
    // mid-frame never produces a rise that could commit a word
    wire       sel_fall = sel_n_d & ~sel_n;
    wire       sel_rise = ~sel_n_d & sel_n;
    wire       sclk_up  = ~sel_n & sclk & ~pin3_q[1];
    wire       sclk_dn  = ~sel_n & ~sclk & pin3_q[1];
    wire [9:0] fault_raw = sync2_q[9:0];

    // =============================================================
    // Fault filters: a level must persist for the filter time
    // One counter per level costs area but keeps each fault's
    // filter time independent of the others
    localparam NF = 10;
    localparam CW = 12;
    wire [NF-1:0] filt;      // Filtered fault register
    reg           frame_ok;  // Valid frame accepted this cycle

    genvar g;
    generate
        for (g = 0; g < NF; g = g + 1)
        begin : g_filt
            reg [CW-1:0] cnt_q;  // Persistence count
            reg          hit_q;  // Filtered level
            // Count parks at its end value while the fault stays
            always @(posedge I_SYS_CLK or negedge I_RST_N)
            begin
                if (!I_RST_N)
                begin
                    cnt_q <= {CW{1'b0}};
                    hit_q <= 1'b0;
                end
                else if (frame_ok | ~fault_raw[g] | sleep)
                begin
                    // Valid frame clears; live faults come back later
                    cnt_q <= {CW{1'b0}};
                    hit_q <= 1'b0;
                end
                else if (cnt_q == FILTER_CYC[CW-1:0] - 1'b1)
                    hit_q <= 1'b1;
                else
                    cnt_q <= cnt_q + 1'b1;
            end
            assign filt[g] = hit_q;
        end
    endgenerate

    // Supply levels gate the drivers directly, not only the flags
    // Index order follows the synchroniser bus above
    wire ov_now = filt[7];
    wire uv_now = filt[8];

    // =============================================================
    // Frame shifter and length check
    reg  [15:0] sh_q;    // Status out at bit 0, command in at bit 15
    reg  [3:0]  len_q;   // Rising edges modulo 16
    reg         any_q;   // At least one rising edge seen
    reg  [15:0] pend_q;  // Accepted word awaiting the FIFO
    reg         pvld_q;  // Pending word valid
    wire [15:0] status;
    wire        fifo_in_rdy;

    // Judged at the select rise, after the last fall has landed;
    // a frame with no rising edge is refused like a bad length
    always @*
        frame_ok = sel_rise & any_q & (len_q == 4'h0);

    // One register serves both directions: status drains from
    // bit 0 while command bits fill from bit 15
    // Hazard: serial in is read from stage two in the same cycle the fall is seen,
    // so the host must hold it for a full system clock period
    always @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            sh_q   <= 16'h0000;
            len_q  <= 4'h0;
            any_q  <= 1'b0;
            pend_q <= 16'h0000;
            pvld_q <= 1'b0;
        end
        else
        begin
            if (sel_fall)
            begin
                // Status loaded so thermal bit shows at once
                sh_q  <= status;
                len_q <= 4'h0;
                any_q <= 1'b0;
            end
            else if (sclk_up)
            begin
                // Next status bit out, low bit first
                sh_q  <= {1'b0, sh_q[15:1]};
                len_q <= len_q + 4'h1;
                any_q <= 1'b1;
            end
            else if (sclk_dn)
                // Incoming bit enters at the top; old ones pass on
                sh_q[15] <= sin;
            // Bad length leaves pend untouched: word discarded
            if (frame_ok)
            begin
                pend_q <= sh_q;
                pvld_q <= 1'b1;
            end
            else if (pvld_q & fifo_in_rdy)
                pvld_q <= 1'b0;
        end
    end

    // Released while select is high, and during sleep
    // The pad cell owns the tristate; this block only gives the
    // enable, low while the pin is driven
    assign O_SERIAL_OUT      = sh_q[0];
    assign O_SERIAL_OUT_OE_N = sel_n;

    // =============================================================
    // Command FIFO: apply side stalls in sleep
    // Limitation: a frame landing while the FIFO is full overwrites
    // the pending word; the select gap between frames keeps hosts
    // far from that case
    wire        cmd_vld;
    wire [15:0] cmd_word;
    wire        apply = cmd_vld & wake;

    hbs_fifo #(
        .WIDTH (`HBS_WORD_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk         (I_SYS_CLK),
        .rst_n       (I_RST_N),
        .i_in_valid  (pvld_q),
        .o_in_ready  (fifo_in_rdy),
        .i_in_data   (pend_q),
        .o_out_valid (cmd_vld),
        .i_out_ready (wake),
        .o_out_data  (cmd_word)
    );

    // =============================================================
    // Shutdown-mode decode, shared by the clear and latch paths
    function shut_mode;
        input [15:0] word;
        begin
            shut_mode = word[`HBS_CMD_OCD_BIT];
        end
    endfunction

    // =============================================================
    // Command register, latched-off drivers, sticky flags
    // Unused command bits are stored but drive nothing
    reg  [15:0] cmd_q;   // Programmed command word
    reg  [5:0]  off_q;   // Drivers latched off by overcurrent
    reg  [3:0]  flag_q;  // {supply, underload, overload, thermal}
    wire        status_clear_cmd     = apply & cmd_word[`HBS_CMD_SRR_BIT];
    wire [3:0]  flag_set = {ov_now | uv_now, filt[6],
                            |filt[5:0], filt[9]};

    // Sleep wins over all; a clear command beats the latches, but a
    // live filtered fault sets them again in the same cycle
    always @(posedge I_SYS_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            cmd_q  <= `HBS_CMD_RESET;
            off_q  <= 6'h00;
            flag_q <= `HBS_FLAG_RESET;
        end
        else if (sleep)
        begin
            // Sleep drops all programmed state
            cmd_q  <= `HBS_CMD_RESET;
            off_q  <= 6'h00;
            flag_q <= `HBS_FLAG_RESET;
        end
        else
        begin
            if (apply)
                cmd_q <= cmd_word;
            // Clear first, then set so a new event wins
            if (status_clear_cmd)
                flag_q <= flag_set;
            else
                flag_q <= flag_q | flag_set;
            // Shutdown mode latches a driver off until clear
            if (status_clear_cmd)
                off_q <= shut_mode(cmd_q) ? filt[5:0] : 6'h00;
            else if (shut_mode(cmd_q))
                off_q <= off_q | filt[5:0];
        end
    end

    // =============================================================
    // Driver gating; programmed states kept through overvoltage
    // Undervoltage always forces off; overvoltage only when enabled
    // Sleep gates too, so a waking host finds every driver off
    wire ov_kill = cmd_q[`HBS_CMD_OVERVOLTAGE_LOCKOUT_CTRL_BIT] & ov_now;
    wire [5:0] drv = cmd_q[`HBS_DRV_MSB:`HBS_DRV_LSB] & ~off_q
                     & {6{~ov_kill & ~uv_now & wake}};

    assign O_DRIVER_ON = drv;
    assign O_SLEEP     = sleep;

    // Status word: flags, unused zeros, driver states, thermal
    // Driver bits give the gated state: a latched-off driver reads 0
    assign status = {flag_q[3], flag_q[2], flag_q[1], 6'h00,
                     drv, flag_q[0]};
endmodule

// file: verification/hbs_spi_checker.sv
`timescale 1ns/10ps
// ==========
// Port checks: select, sleep, serial out, drivers
module hbs_spi_checker (
    input wire       I_SYS_CLK,
    input wire       I_RST_N,
    input wire       I_SELECT_N,
    input wire       I_SHIFT_CLOCK,
    input wire       I_WAKE,
    input wire [5:0] I_OVERCURRENT,
    input wire       I_OVERVOLTAGE,
    input wire       I_UNDERVOLTAGE,
    input wire       O_SERIAL_OUT,
    input wire       O_SERIAL_OUT_OE_N,
    input wire [5:0] O_DRIVER_ON,
    input wire       O_SLEEP
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    property p_oe_idle;
        I_SELECT_N [*4] |-> O_SERIAL_OUT_OE_N;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("out driven");
    property p_oe_act;
        (!I_SELECT_N && I_WAKE) [*5] |-> !O_SERIAL_OUT_OE_N;
    endproperty
    a_oe_act: assert property (p_oe_act) else $error("out not driven");
    property p_oe_cause;
        $fell(O_SERIAL_OUT_OE_N) |-> !$past(I_SELECT_N);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("early enable");
    property p_sleep_oe;
        (!I_WAKE) [*4] |-> O_SERIAL_OUT_OE_N && O_SLEEP;
    endproperty
    a_sleep_oe: assert property (p_sleep_oe) else $error("out in sleep");
    property p_sleep_drv;
        (!I_WAKE) [*4] |-> O_DRIVER_ON == 6'h00;
    endproperty
    a_sleep_drv: assert property (p_sleep_drv) else $error("drive in sleep");
    property p_sleep_pin;
        $stable(I_WAKE) [*4] |-> O_SLEEP == !I_WAKE;
    endproperty
    a_sleep_pin: assert property (p_sleep_pin) else $error("sleep level");
    property p_so_hold;
        (!I_SELECT_N && !I_SHIFT_CLOCK) [*7] |-> $stable(O_SERIAL_OUT);
    endproperty
    a_so_hold: assert property (p_so_hold) else $error("out moved");
    property p_drv_frame;
        (!I_SELECT_N && I_WAKE && !I_OVERVOLTAGE && !I_UNDERVOLTAGE
            && I_OVERCURRENT == 6'h00) [*8] |-> $stable(O_DRIVER_ON);
    endproperty
    a_drv_frame: assert property (p_drv_frame) else $error("drive in frame");
    // Main scenarios reached
    cover property ($fell(O_SERIAL_OUT_OE_N));
    cover property ($rose(O_SLEEP));
    cover property ($changed(O_DRIVER_ON) && !O_SLEEP);
endmodule

bind hbs_spi hbs_spi_checker chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N),
    .I_SELECT_N(I_SELECT_N), .I_SHIFT_CLOCK(I_SHIFT_CLOCK), .I_WAKE(I_WAKE),
    .I_OVERCURRENT(I_OVERCURRENT), .I_OVERVOLTAGE(I_OVERVOLTAGE),
    .I_UNDERVOLTAGE(I_UNDERVOLTAGE), .O_SERIAL_OUT(O_SERIAL_OUT),
    .O_SERIAL_OUT_OE_N(O_SERIAL_OUT_OE_N), .O_DRIVER_ON(O_DRIVER_ON), .O_SLEEP(O_SLEEP));

// file: verification/hbs_host.sv
`timescale 1ns/10ps
// ==========
// Host master: frames words, link clock idles low
module hbs_host (
    output logic o_select_n,
    output logic o_shift_clock,
    output logic o_serial_in,
    input  wire  i_serial_out
);
    int hp = 100;                       // Half period; raise it for a slow host
    initial
    begin
        o_select_n    = 1'b1;           // Idle deselected
        o_shift_clock = 1'b0;
        o_serial_in   = 1'b0;
    end
    // Shift n bits LSB first, read back before each rise
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0000_0000;
        o_select_n  = 1'b0;
        o_serial_in = tx[0];
        #(2 * hp);
        if (n == 0)
            rx[0] = i_serial_out;
        for (int i = 0; i < n; i++)
        begin
            rx[i] = i_serial_out;
            o_shift_clock = 1'b1;
            #hp o_shift_clock = 1'b0;
            // Data moves well after the fall, held past one system clock
            #(hp / 2) o_serial_in = tx[(i + 1) % 32]; // Off the sampling edge
            #(hp - hp / 2);
        end
        o_select_n = 1'b1;              // Clock already low
        #(4 * hp);
    endtask
endmodule

// file: verification/test_hbs_spi.sv
`timescale 1ns/10ps
// ==========
// Bench: host model against a reference of command and flags
module test_hbs_spi;
    localparam int FILT = 6;            // Short filter keeps runs brief
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wake = 1'b1;
    logic [5:0]  oc = 6'h00;
    logic        ul = 1'b0, ov = 1'b0, uv = 1'b0, tw = 1'b0;
    logic        tgl = 1'b0;            // Pattern on the released line
    logic [31:0] rx;
    logic [15:0] a, b;
    wire         sel_n, sclk, si, so, oe_n, slp;
    wire  [5:0]  drv;
    wire         so_line = oe_n ? tgl : so;
    int          miscompares = 0, num_checks = 0, cyc = 0;
    int          m_drv = 0, m_st = 0;   // Model of driver state and flags
    int          exp_q[$];              // Status words awaiting their frame
    int          pos[5] = '{1, 1 << 13, 1 << 14, 1 << 15, 1 << 15};
    int          bad[4] = '{0, 15, 17, 31};
    hbs_spi #(.FILTER_CYC(FILT)) dut_u (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_SELECT_N(sel_n), .I_SHIFT_CLOCK(sclk),
        .I_SERIAL_IN(si), .O_SERIAL_OUT(so), .O_SERIAL_OUT_OE_N(oe_n), .I_WAKE(wake),
        .I_OVERCURRENT(oc), .I_UNDERLOAD(ul), .I_OVERVOLTAGE(ov), .I_UNDERVOLTAGE(uv),
        .I_THERMAL_WARN(tw), .O_DRIVER_ON(drv), .O_SLEEP(slp));
    hbs_host host_u (.o_select_n(sel_n), .o_shift_clock(sclk), .o_serial_in(si),
        .i_serial_out(so_line));
    always #12.5 clk = ~clk;
    // Line pattern and hang guard
    always @(posedge clk)
    begin
        tgl <= ~tgl;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    function automatic logic [15:0] st_exp();
        st_exp = 16'(m_st | (m_drv << 1));
    endfunction
    task automatic frame(input int n, input logic [31:0] tx);
        host_u.xfer(n, tx, rx);
        wait_clk(12);
    endtask
    // Valid word: status back, then command applied
    task automatic send(input logic [15:0] c);
        exp_q.push_back(st_exp());
        frame(16, {16'h0000, c});
        check(rx[15:0], exp_q.pop_front());
        if (c[0])
            m_st = 0;
        m_drv = c[6:1];
        check(drv, m_drv[5:0]);
    endtask
    initial
    begin
        void'($urandom(7906));
        repeat (4) @(posedge clk);
        #2 rst_n = 1'b1;
        wait_clk(4);
        send(16'h0000);
        host_u.hp = 160;
        repeat (4) send(16'($urandom) & 16'h5FFE);
        host_u.hp = 100;
        foreach (bad[i])
        begin
            frame(bad[i], $urandom);
            check(drv, m_drv[5:0]);
        end
        a = 16'($urandom) & 16'h007E;
        b = 16'($urandom) & 16'h007E;
        frame(32, {b, a});
        check(rx, {a, st_exp()});
        m_drv = b[6:1];
        check(drv, m_drv[5:0]);
        send(16'h007E);
        // Each fault latches, survives a plain word, clears on bit 0
        for (int k = 0; k < 5; k++)
        begin
            {uv, ov, ul, oc[2], tw} = 5'h01 << k;
            wait_clk(FILT + 10);
            {uv, ov, ul, oc[2], tw} = 5'h00;
            wait_clk(FILT + 10);
            m_st = pos[k];
            frame(0, 0);
            check(rx[0], m_st[0]);
            send(16'h007E);
            send(16'h007F);
            send(16'h007E);
        end
        ul = 1'b1;
        wait_clk(FILT + 10);
        m_st = pos[2];
        send(16'h007F);
        m_st = pos[2];
        wait_clk(FILT + 10);
        ul = 1'b0;
        send(16'h007F);
        send(16'h207E);
        oc[2] = 1'b1;
        wait_clk(FILT + 10);
        oc[2] = 1'b0;
        wait_clk(FILT + 10);
        m_drv = 'h3B;
        m_st = pos[1];
        check(drv, 6'h3B);
        send(16'h207F);
        send(16'h807E);
        ov = 1'b1;
        wait_clk(FILT + 10);
        check(drv, 6'h00);
        ov = 1'b0;
        wait_clk(FILT + 10);
        check(drv, 6'h3F);
        m_st = pos[3];
        send(16'h807F);
        wake = 1'b0;
        wait_clk(4);
        check({slp, oe_n, drv}, 8'hC0);
        frame(16, 32'h0000_007E);
        wake = 1'b1;
        wait_clk(4);
        m_drv = 0;
        check(drv, 6'h00);
        send(16'h0000);
        print_verdict();
    end
endmodule
